// ### rtl/eps_deadband.sv
// one dead-band channel: delays the rise of its active level
`timescale 1ns/1ns
module eps_deadband (
    input  wire logic   core_clk_i,
    input  wire logic   arst_n_i,
    eps_db_if.chan      db
);
    import eps_pkg::*;

    typedef struct packed {
        logic [DB_TGT_W-1:0] cnt;
        logic                act;
    } eps_db_s;

    eps_db_s st_ff;
    eps_db_s nxt_st;

    // count clocks while requested; a request shorter than the delay never shows
    always_comb
    begin
        nxt_st = st_ff;
        if (!db.req)
        begin
            nxt_st.cnt = CNT_RST;
            nxt_st.act = 1'b0;
        end
        else if (st_ff.cnt >= db.target)
            nxt_st.act = 1'b1;
        else
            nxt_st.cnt = st_ff.cnt + 9'h001;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            st_ff <= '{cnt: CNT_RST, act: 1'b0};
        else
            st_ff <= nxt_st;
    end

    assign db.act = st_ff.act;

    // falling toward inactive is never delayed
    property p_db_fall;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !db.req |=> !db.act;
    endproperty
    a_db_fall: assert property (p_db_fall)
        else $error("dead-band output stayed active after request fell");

    // a nonzero delay keeps the output inactive for the first two cycles
    property p_db_hold;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        ($rose(db.req) && db.target != 9'h000) |=> !db.act ##1 !db.act;
    endproperty
    a_db_hold: assert property (p_db_hold)
        else $error("dead-band output went active before its delay");
endmodule

// ### rtl/eps_output_stage.sv
// pwm output stage: half-bridge, dead-band, auto-shutdown, steering
//
// Summary of operation
// - half-bridge drives waveform and its complement
// - dead-band counted in four-clock instruction cycles
// - delay only on inactive to active edges
// - delay above duty keeps output inactive
// - source select enables pin, comparator, firmware
// - status can read zero while outputs stay shut until the next period start
// - shutdown sets status until cleared or restart
// - pin and comparator shutdown force pins without waiting a clock
// - each pin group picks high, low, tristate
// - shutdown follows source level, not edges
// - status writes ignored while condition present
// - restart resumes at next period start
// - auto-restart clears status when condition goes
// - single mode steers waveform to either pin
// - mode low bits set steered pin polarity
// - shutdown touches only enabled pins: both in half-bridge, steering-enabled ones in single mode
// - mode codes 1100 to 1111 select pwm
// - output configuration 10 selects half-bridge
// - steering sync picks period start or immediate
`timescale 1ns/1ns
module eps_output_stage (
    input  wire logic                   core_clk_i,
    input  wire logic                   arst_n_i,
    // time base
    input  wire logic                   pwm_raw_i,
    input  wire logic                   period_start_i,
    // configuration
    input  wire logic [3:0]             module_mode_select_i,
    input  wire logic [1:0]             output_configuration_i,
    input  wire logic [eps_pkg::DB_W-1:0] deadband_count_i,
    input  wire logic                   auto_restart_enable_i,
    input  wire logic [2:0]             shutdown_source_select_i,
    input  wire logic [1:0]             shutdown_state_group_a_i,
    input  wire logic [1:0]             shutdown_state_group_b_i,
    input  wire logic [1:0]             steering_enable_bits_i,
    input  wire logic                   steering_sync_select_i,
    // firmware access to the status bit
    input  wire logic                   shutdown_status_wr_i,
    input  wire logic                   shutdown_status_wdata_i,
    // shutdown sources
    input  wire logic                   ext_int_pin_i,
    input  wire logic                   comparator_one_i,
    // status and pins
    output logic                        shutdown_event_status_o,
    output logic                        pwm_out_primary_o,
    output logic                        pwm_out_primary_oe_o,
    output logic                        pwm_out_secondary_o,
    output logic                        pwm_out_secondary_oe_o
);
    import eps_pkg::*;

    typedef struct packed {
        logic       status;
        logic       hold;
        logic       run;
        logic [1:0] steer;
        logic       out_a;
        logic       out_b;
        logic       oe_a;
        logic       oe_b;
    } eps_stage_s;

    eps_stage_s st_ff;
    eps_stage_s nxt_st;

    // shutdown level from the selected hardware sources
    function automatic logic sd_cond(
        input logic [2:0] sel,
        input logic       ext_lvl,
        input logic       cmp_lvl
    );
        sd_cond = (sel[SRC_EXT_BIT] & ~ext_lvl) | (sel[SRC_CMP_BIT] & cmp_lvl);
    endfunction

    // pin override: returns {oe, level}; a released pin is never forced
    function automatic logic [1:0] shut_pin(
        input logic [1:0] ss,
        input logic       force_sd,
        input logic       oe,
        input logic       lvl
    );
        if (!oe || !force_sd)
            shut_pin = {oe, lvl};
        else if (ss[SS_TRI_BIT])
            shut_pin = 2'h0;
        else if (ss == SS_DRIVE_HI)
            shut_pin = 2'h3;
        else
            shut_pin = 2'h2;
    endfunction

    logic [1:0] src_sync;
    logic       ext_s;
    logic       cmp_s;
    logic       cond_sync;
    logic       cond_raw;
    logic       mode_pwm;
    logic       half;
    logic       single;
    logic       pol_a;
    logic       pol_b;
    logic       fw_set;
    logic       fw_clr;
    logic       en_a;
    logic       en_b;
    logic       force_sd;
    logic [1:0] pin_a;
    logic [1:0] pin_b;
    logic [DB_TGT_W-1:0] db_target;

    eps_db_if db_a ();
    eps_db_if db_b ();

    // two flops before status logic; pin enters inverted so a zero reset means idle
    eps_sync2 #(
        .W (2)
    ) u_src_sync (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .async_i    ({comparator_one_i, ~ext_int_pin_i}),
        .sync_o     (src_sync)
    );

    assign ext_s = ~src_sync[0];
    assign cmp_s = src_sync[1];

    // decode of mode and output configuration
    assign mode_pwm = (module_mode_select_i[3:2] == MODE_PWM_SEL);
    assign half     = mode_pwm && (output_configuration_i == OCFG_HALF);
    assign single   = mode_pwm && (output_configuration_i == OCFG_SINGLE);
    assign pol_a    = module_mode_select_i[POL_A_BIT];
    assign pol_b    = module_mode_select_i[POL_B_BIT];

    // level-sensitive conditions; the raw one skips the synchroniser on purpose
    assign cond_sync = sd_cond(shutdown_source_select_i, ext_s, cmp_s);
    assign cond_raw  = sd_cond(shutdown_source_select_i,
                               ext_int_pin_i, comparator_one_i);

    // firmware access; a write of one is itself a shutdown source
    assign fw_set = shutdown_status_wr_i && shutdown_status_wdata_i
                    && shutdown_source_select_i[SRC_FW_BIT];
    assign fw_clr = shutdown_status_wr_i && !shutdown_status_wdata_i;

    // dead-band only applies in half-bridge; steering passes straight through
    assign db_target = half ? DB_TGT_W'(deadband_count_i) * DB_TGT_W'(TCY_CYCLES)
                            : CNT_RST;

    // channel requests: complement on the secondary in half-bridge
    assign db_a.req    = st_ff.run && pwm_raw_i;
    assign db_b.req    = st_ff.run && (half ? !pwm_raw_i : pwm_raw_i);
    assign db_a.target = db_target;
    assign db_b.target = db_target;

    eps_deadband u_db_a (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .db         (db_a)
    );

    eps_deadband u_db_b (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .db         (db_b)
    );

    // pins are enabled by mode and, in single mode, by steering
    assign en_a = half || (single && st_ff.steer[STR_A_BIT]);
    assign en_b = half || (single && st_ff.steer[STR_B_BIT]);

    // next state of the whole stage
    always_comb
    begin
        nxt_st = st_ff;

        // status: a live condition beats any firmware clear
        if (cond_sync || fw_set)
            nxt_st.status = 1'b1;
        else if (fw_clr)
            nxt_st.status = 1'b0;
        else if (auto_restart_enable_i && st_ff.status)
            nxt_st.status = 1'b0;

        // outputs stay shut until a period starts with status clear
        if (st_ff.status || cond_sync || fw_set)
            nxt_st.hold = 1'b1;
        else if (period_start_i)
            nxt_st.hold = 1'b0;

        // a fresh enable waits for a period start to avoid a partial pulse
        if (!(half || single))
            nxt_st.run = 1'b0;
        else if (period_start_i)
            nxt_st.run = 1'b1;

        // steering update, immediate or at period start
        if (!steering_sync_select_i || period_start_i)
            nxt_st.steer = steering_enable_bits_i;

        // registered pin levels with polarity applied
        nxt_st.out_a = db_a.act ^ pol_a;
        nxt_st.out_b = db_b.act ^ pol_b;
        nxt_st.oe_a  = en_a;
        nxt_st.oe_b  = en_b;
    end

    // only constants under reset; pins released until configured
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            st_ff <= '{status: 1'b0, hold: 1'b0, run: 1'b0, steer: STEER_RST,
                       out_a: 1'b0, out_b: 1'b0, oe_a: 1'b0, oe_b: 1'b0};
        else
            st_ff <= nxt_st;
    end

    // forcing is combinational so a pin or comparator fault reaches the pins with no clock; a firmware shutdown waits for hold
    assign force_sd = st_ff.hold || cond_raw;
    assign pin_a    = shut_pin(shutdown_state_group_a_i, force_sd,
                               st_ff.oe_a, st_ff.out_a);
    assign pin_b    = shut_pin(shutdown_state_group_b_i, force_sd,
                               st_ff.oe_b, st_ff.out_b);

    assign pwm_out_primary_oe_o   = pin_a[1];
    assign pwm_out_primary_o      = pin_a[0];
    assign pwm_out_secondary_oe_o = pin_b[1];
    assign pwm_out_secondary_o    = pin_b[0];
    assign shutdown_event_status_o = st_ff.status;

    // a synchronised condition sets the status on the next edge
    property p_sd_set;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        cond_sync |=> shutdown_event_status_o;
    endproperty
    a_sd_set: assert property (p_sd_set)
        else $error("shutdown condition did not set the status");

    // a clear write cannot drop the status under a live condition
    property p_sw_ignored;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (cond_sync && fw_clr) |=> shutdown_event_status_o;
    endproperty
    a_sw_ignored: assert property (p_sw_ignored)
        else $error("status cleared while shutdown condition present");

    // auto-restart clears the status one edge after the condition goes
    property p_auto_clear;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (shutdown_event_status_o && auto_restart_enable_i && !cond_sync && !fw_set)
            |=> !shutdown_event_status_o;
    endproperty
    a_auto_clear: assert property (p_auto_clear)
        else $error("auto-restart did not clear the status");

    // without auto-restart only firmware clears the status
    property p_sticky;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (shutdown_event_status_o && !auto_restart_enable_i && !fw_clr)
            |=> shutdown_event_status_o;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("status dropped without a clear");

    // pins leave shutdown only on a period start
    property p_restart_period;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        $fell(st_ff.hold) |-> $past(period_start_i);
    endproperty
    a_restart_period: assert property (p_restart_period)
        else $error("outputs resumed away from a period start");

    // raw condition drives the low shutdown level in the same cycle
    property p_async_force;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (cond_raw && st_ff.oe_a && shutdown_state_group_a_i == SS_DRIVE_LO)
            |-> (pwm_out_primary_oe_o && !pwm_out_primary_o);
    endproperty
    a_async_force: assert property (p_async_force)
        else $error("primary pin not forced low on shutdown");

    // tristate shutdown state releases an enabled pin
    property p_tristate;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (force_sd && shutdown_state_group_b_i[SS_TRI_BIT]) |-> !pwm_out_secondary_oe_o;
    endproperty
    a_tristate: assert property (p_tristate)
        else $error("secondary pin driven in tristate shutdown");

    // dead-band never lets both half-bridge sides be active together
    property p_no_overlap;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (half && $past(half)) |-> !(db_a.act && db_b.act);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("both half-bridge outputs active at once");

    // steered pins carry the same waveform once single mode settles
    property p_steer_same;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (single && $past(single) && $past(single, 2)) |-> (db_a.act == db_b.act);
    endproperty
    a_steer_same: assert property (p_steer_same)
        else $error("steered pins carry different waveforms");

    // synchronised steering holds between period starts
    property p_steer_sync;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (steering_sync_select_i && !period_start_i) |=> $stable(st_ff.steer);
    endproperty
    a_steer_sync: assert property (p_steer_sync)
        else $error("steering changed away from a period start");

    // outside pwm mode both pins are released
    property p_pwm_off;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !mode_pwm [*2] |-> (!pwm_out_primary_oe_o && !pwm_out_secondary_oe_o);
    endproperty
    a_pwm_off: assert property (p_pwm_off)
        else $error("pin driven outside pwm mode");
endmodule

// ### rtl/eps_sync2.sv
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ns
module eps_sync2 #(
    parameter int W = 2
) (
    input  wire logic           core_clk_i,
    input  wire logic           arst_n_i,
    input  wire logic [W-1:0]   async_i,
    output logic      [W-1:0]   sync_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } eps_sync_s;

    eps_sync_s st_ff;
    eps_sync_s nxt_st;

    // first stage feeds only the second stage
    always_comb
    begin
        nxt_st.s1 = async_i;
        nxt_st.s2 = st_ff.s1;
    end

    // reset value is the idle level of both sources
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            st_ff <= '{s1: {W{1'b0}}, s2: {W{1'b0}}};
        else
            st_ff <= nxt_st;
    end

    assign sync_o = st_ff.s2;
endmodule

// ### shared/eps_db_if.sv
// request and answer of one dead-band channel
`timescale 1ns/1ns
interface eps_db_if;
    import eps_pkg::*;
    logic                   req;
    logic [DB_TGT_W-1:0]    target;
    logic                   act;

    modport ctrl (output req, output target, input act);
    modport chan (input req, input target, output act);
endinterface

// ### shared/eps_pkg.sv
// constants shared by the pwm output stage modules
package eps_pkg;
    // clock and dead-band timing
    localparam int          CLK_PERIOD_NS   = 4;
    localparam int          TOSC_NS         = 4;
    localparam int          TOSC_PER_TCY    = 4;
    localparam int          TCY_NS          = TOSC_PER_TCY * TOSC_NS;
    localparam int          TCY_CYCLES      = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          DB_W            = 7;
    localparam int          DB_TGT_W        = 9;

    // mode select field
    localparam logic [1:0]  MODE_PWM_SEL    = 2'h3;
    localparam int          POL_A_BIT       = 1;
    localparam int          POL_B_BIT       = 0;

    // output configuration codes
    localparam logic [1:0]  OCFG_SINGLE     = 2'h0;
    localparam logic [1:0]  OCFG_HALF       = 2'h2;

    // shutdown source select bit positions
    localparam int          SRC_EXT_BIT     = 0;
    localparam int          SRC_CMP_BIT     = 1;
    localparam int          SRC_FW_BIT      = 2;

    // shutdown state codes per pin group
    localparam logic [1:0]  SS_DRIVE_LO     = 2'h0;
    localparam logic [1:0]  SS_DRIVE_HI     = 2'h1;
    localparam int          SS_TRI_BIT      = 1;

    // steering enable bit positions
    localparam int          STR_A_BIT       = 0;
    localparam int          STR_B_BIT       = 1;

    // reset values
    localparam logic [1:0]  STEER_RST       = 2'h0;
    localparam logic [DB_TGT_W-1:0] CNT_RST = 9'h000;
endpackage

// ### test/eps_bridge_model.sv
// partner model: the two power switches hanging on the output pins
`timescale 1ns/1ns
module eps_bridge_model (
    input  wire logic        core_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        hi_lvl_i,
    input  wire logic        hi_oe_i,
    input  wire logic        lo_lvl_i,
    input  wire logic        lo_oe_i,
    input  wire logic        armed_i,
    output logic             hi_gate_o,
    output logic             lo_gate_o,
    output logic [15:0]      overlap_o
);
    // pull-downs hold a released gate off, so an undriven pin shows no waveform
    assign hi_gate_o = hi_oe_i ? hi_lvl_i : 1'b0;
    assign lo_gate_o = lo_oe_i ? lo_lvl_i : 1'b0;

    // both switches on together would short the supply, so count it
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            overlap_o <= 16'h0000;
        else if (armed_i && hi_gate_o && lo_gate_o)
            overlap_o <= overlap_o + 16'h0001;
    end
endmodule

// ### test/eps_output_stage_tb.sv
// self-checking bench for the pwm output stage
`timescale 1ns/1ns
`define CHK(obs, exp) \
    begin \
        num_checks++; \
        if ((obs) !== (exp)) \
        begin \
            mismatches++; \
            $display("Error at %0t: got %b expected %b", $time, (obs), (exp)); \
        end \
    end
module eps_output_stage_tb;
    import eps_pkg::*;
    typedef struct {logic [4:0] val; logic [4:0] mask;} eps_note_s;

    logic        clk = 1'b0;
    logic        arst_n, raw, pstart, auto_rs, fw_wr, fw_d, ext_n, cmp, sync_sel, armed;
    logic [3:0]  mode;
    logic [1:0]  ocfg, ss_a, ss_b, steer;
    logic [6:0]  db;
    logic [2:0]  src_sel;
    logic        status, p_lvl, p_oe, s_lvl, s_oe, p_wire, s_wire;
    logic [15:0] overlap;
    logic [4:0]  obs;
    int          mismatches = 0;
    int          num_checks = 0;
    int          seed = 96614;
    eps_note_s   notes[$];
    event        probe;

    assign obs = {status, p_wire, p_oe, s_wire, s_oe};

    // clock at 250 MHz
    always #2 clk = ~clk;

    eps_output_stage DUT (
        .core_clk_i(clk), .arst_n_i(arst_n), .pwm_raw_i(raw), .period_start_i(pstart),
        .module_mode_select_i(mode), .output_configuration_i(ocfg), .deadband_count_i(db),
        .auto_restart_enable_i(auto_rs), .shutdown_source_select_i(src_sel),
        .shutdown_state_group_a_i(ss_a), .shutdown_state_group_b_i(ss_b),
        .steering_enable_bits_i(steer), .steering_sync_select_i(sync_sel),
        .shutdown_status_wr_i(fw_wr), .shutdown_status_wdata_i(fw_d),
        .ext_int_pin_i(ext_n), .comparator_one_i(cmp), .shutdown_event_status_o(status),
        .pwm_out_primary_o(p_lvl), .pwm_out_primary_oe_o(p_oe),
        .pwm_out_secondary_o(s_lvl), .pwm_out_secondary_oe_o(s_oe));

    eps_bridge_model u_bridge (
        .core_clk_i(clk), .arst_n_i(arst_n), .hi_lvl_i(p_lvl), .hi_oe_i(p_oe),
        .lo_lvl_i(s_lvl), .lo_oe_i(s_oe), .armed_i(armed), .hi_gate_o(p_wire),
        .lo_gate_o(s_wire), .overlap_o(overlap));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // inputs move 1 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // the #0 lets the monitor sample before the driver moves on
    task automatic expect_pins(input logic [4:0] v, input logic [4:0] m);
        notes.push_back('{v, m});
        -> probe;
        #0;
    endtask

    task automatic period_pulse();
        pstart = 1'b1;
        cyc(1);
        pstart = 1'b0;
    endtask

    task automatic fw_write(input logic d);
        fw_wr = 1'b1;
        fw_d = d;
        cyc(1);
        fw_wr = 1'b0;
    endtask

    // one shutdown from source src: hold, refused clear and release for hardware sources, restart
    task automatic shut_run(input int src, input logic [1:0] ssa, input logic [1:0] ssb,
                            input logic ar, input logic [3:0] run);
        logic [3:0] f;
        f[3:2] = (run[2] && !ssa[1]) ? {ssa[0], 1'b1} : 2'b00;
        f[1:0] = (run[0] && !ssb[1]) ? {ssb[0], 1'b1} : 2'b00;
        src_sel = 3'b001 << src;
        ss_a = ssa;
        ss_b = ssb;
        auto_rs = ar;
        cyc(2);
        expect_pins({1'b0, run}, 5'h1f);
        if (src == 2)
        begin
            fw_write(1'b1);
            expect_pins({1'b1, f}, 5'h1f);
        end
        else
        begin
            ext_n = (src != 0);
            cmp = (src == 1);
            #1;
            expect_pins({1'b0, f}, 5'h0f);
            cyc(4);
            expect_pins({1'b1, f}, 5'h1f);
            fw_write(1'b0);
            cyc(1);
            expect_pins({1'b1, f}, 5'h1f);
            repeat (10)
            begin
                raw = 1'($random(seed));
                cyc(1);
            end
            expect_pins({1'b1, f}, 5'h1f);
            raw = 1'b1;
            ext_n = 1'b1;
            cmp = 1'b0;
        end
        cyc(5);
        expect_pins({~ar, f}, 5'h1f);
        if (!ar)
        begin
            fw_write(1'b0);
            cyc(1);
            expect_pins({1'b0, f}, 5'h1f);
        end
        period_pulse();
        cyc(4);
        expect_pins({1'b0, run}, 5'h1f);
    endtask

    // monitor: every probe takes the oldest notes and compares them
    initial
    begin
        eps_note_s n;
        forever
        begin
            @(probe);
            while (notes.size() > 0)
            begin
                n = notes.pop_front();
                `CHK(obs & n.mask, n.val & n.mask)
            end
        end
    end

    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        stop_test();
    end

    initial
    begin
        {arst_n, raw, pstart, auto_rs, fw_wr, fw_d, cmp, sync_sel, armed} = '0;
        ext_n = 1'b1;
        {mode, ocfg, ss_a, ss_b, steer, db, src_sel} = '0;
        repeat (16) @(posedge clk);
        #1;
        arst_n = 1'b1;
        expect_pins(5'h00, 5'h1f);
        $display("test reset done");
        // half-bridge, no dead-band, every polarity code
        ocfg = OCFG_HALF;
        mode = 4'hc;
        raw = 1'b1;
        cyc(2);
        period_pulse();
        for (int i = 0; i < 4; i++)
        begin
            mode = {MODE_PWM_SEL, i[1:0]};
            cyc(4);
            expect_pins({1'b0, ~i[1], 1'b1, i[0], 1'b1}, 5'h1f);
        end
        mode = 4'hc;
        armed = 1'b1;
        raw = 1'b0;
        cyc(4);
        expect_pins(5'b00111, 5'h1f);
        $display("test half-bridge done");
        // dead-band of 3 instruction cycles, 12 clocks, on both edges
        db = 7'h03;
        raw = 1'b1;
        cyc(3);
        expect_pins(5'b00101, 5'h1f);
        cyc(8);
        expect_pins(5'b00101, 5'h1f);
        cyc(8);
        expect_pins(5'b01101, 5'h1f);
        raw = 1'b0;
        cyc(3);
        expect_pins(5'b00101, 5'h1f);
        cyc(8);
        expect_pins(5'b00101, 5'h1f);
        cyc(8);
        expect_pins(5'b00111, 5'h1f);
        // pulse shorter than the dead-band never reaches the primary pin
        raw = 1'b1;
        for (int i = 0; i < 20; i++)
        begin
            if (i == 6)
                raw = 1'b0;
            cyc(1);
            expect_pins(5'b00100, 5'h1c);
        end
        `CHK(overlap, 16'h0000)
        armed = 1'b0;
        db = 7'h00;
        raw = 1'b1;
        cyc(20);
        $display("test dead-band done");
        // every source, every shutdown state, with and without restart
        shut_run(0, 2'b01, 2'b10, 1'b0, 4'b1101);
        shut_run(1, 2'b00, 2'b01, 1'b1, 4'b1101);
        shut_run(2, 2'b11, 2'b00, 1'b0, 4'b1101);
        shut_run(2, 2'b10, 2'b01, 1'b1, 4'b1101);
        src_sel = 3'b011;
        fw_write(1'b1);
        cyc(1);
        expect_pins(5'b01101, 5'h1f);
        $display("test shutdown done");
        // steering: every enable pattern, every polarity, then sync
        ocfg = OCFG_SINGLE;
        for (int i = 0; i < 4; i++)
        begin
            steer = i[1:0];
            cyc(4);
            expect_pins({1'b0, i[0], i[0], i[1], i[1]}, 5'h1f);
        end
        for (int i = 0; i < 4; i++)
        begin
            mode = {MODE_PWM_SEL, i[1:0]};
            cyc(4);
            expect_pins({1'b0, ~i[1], 1'b1, ~i[0], 1'b1}, 5'h1f);
        end
        mode = 4'hc;
        steer = 2'b01;
        shut_run(0, 2'b01, 2'b01, 1'b1, 4'b1100);
        sync_sel = 1'b1;
        steer = 2'b10;
        cyc(4);
        expect_pins(5'b01100, 5'h1f);
        period_pulse();
        cyc(4);
        expect_pins(5'b00011, 5'h1f);
        mode = 4'h0;
        cyc(4);
        expect_pins(5'b00000, 5'h1f);
        arst_n = 1'b0;
        #1;
        expect_pins(5'b00000, 5'h1f);
        $display("test steering done");
        stop_test();
    end
endmodule
